// ===== lbc_pkg.sv
// Purpose: Shared constants for the logic block with clock generator and allocator
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes: Configuration space is a flat bit vector read and written in 32-bit words
package lbc_pkg;

    // ----------------------------------------------------------------
    // Default sizes
    // ----------------------------------------------------------------
    localparam int DEF_N_DED = 8;
    localparam int DEF_N_IN = 33;
    localparam int DEF_N_PINS = 8;
    localparam int DEF_CELLS_PER_PIN = 2;
    localparam int N_GCLK = 4;
    localparam int N_BCLK = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_CFG_BASE = 12'h100;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Product-term clusters
    // ----------------------------------------------------------------
    localparam int PTC = 5;
    localparam int SYNC_BASIC = 4;
    localparam int ASYNC_BASIC = 2;
    localparam int ASYNC_CLK_PT = 2;
    localparam int ASYNC_INIT_PT = 3;
    localparam int EXTRA_PT = 4;
    localparam int BLOCK_TERMS = 2;

    // ----------------------------------------------------------------
    // Configuration layout
    // ----------------------------------------------------------------
    localparam int CK_SRC_LSB = 0;
    localparam int CK_POL_LSB = 4;
    localparam int CK_CFG_W = 8;
    localparam int CF_MODE = 0;
    localparam int CF_ROUTE = 1;
    localparam int CF_EXT = 3;
    localparam int CF_POL = 4;
    localparam int CF_CLK = 5;
    localparam int CF_PTCLK_POL = 7;
    localparam int CF_INIT_PRE = 8;
    localparam int CELL_CFG_W = 9;
    localparam int ISW_W = 2;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic MODE_SYNC = 1'b0;
    localparam logic MODE_ASYNC = 1'b1;
    localparam logic [1:0] ROUTE_OWN = 2'h0;
    localparam logic [1:0] ROUTE_DOWN = 2'h1;
    localparam logic [1:0] ROUTE_UP = 2'h2;
    localparam logic [1:0] ROUTE_UP2 = 2'h3;
    localparam logic [1:0] ISW_PIN = 2'h0;
    localparam logic [1:0] ISW_FB = 2'h1;
    localparam logic [1:0] ISW_PIN_NEXT = 2'h2;
    localparam logic [1:0] ISW_FB_NEXT = 2'h3;

endpackage

// ===== lbc_alloc_if.sv
// Purpose: Carrier between the block top and the product-term allocator
// Assumes: Top drives terms and per-cell settings, allocator returns XOR inputs
// Notes: Clock and reset ride along for the allocator checks
`timescale 1ns/1ps
interface lbc_alloc_if #(parameter int N_CELLS = 16);
    import lbc_pkg::*;
    logic clk;
    logic reset;
    logic [PTC*N_CELLS-1:0] pt;
    logic [N_CELLS-1:0] mode;
    logic [2*N_CELLS-1:0] route;
    logic [N_CELLS-1:0] ext;
    logic [N_CELLS-1:0] pol;
    logic [N_CELLS-1:0] xor_a;
    logic [N_CELLS-1:0] xor_b;
    logic [N_CELLS-1:0] d;
    modport top (output clk, reset, pt, mode, route, ext, pol, input xor_a, xor_b, d);
    modport alloc (input clk, reset, pt, mode, route, ext, pol, output xor_a, xor_b, d);
endinterface

// ===== lbc_clkgen.sv
// Purpose: Block clock generator, four block clocks from four global clocks
// Assumes: Global clocks arrive already sampled on clk
// Notes: Selections are static while run is high
`timescale 1ns/1ps
module lbc_clkgen
    import lbc_pkg::*;
#(
    parameter int NB = N_BCLK
)(
    input logic clk,
    input logic reset,
    input logic run,
    input logic [N_GCLK-1:0] gclk,
    input logic [NB-1:0] src,
    input logic [NB-1:0] pol,
    output logic [NB-1:0] blk_clk
);

    typedef struct packed {
        logic [NB-1:0] bclk;
    } lbc_clk_state_type;

    lbc_clk_state_type st;
    lbc_clk_state_type nx;
    logic [NB-1:0] want;

    // ----------------------------------------------------------------
    // Pair selection and polarity
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NB; i++) begin : g_bclk
        // Clocks 0/1 from global 0/1, clocks 2/3 from global 2/3
        assign want[i] = gclk[2 * (i / 2) + int'(src[i])] ^ pol[i];

        chk_blk_true_pick: assert property (@(posedge clk) disable iff (reset)
            run && !src[i] && !pol[i] && gclk[2 * (i / 2)] |=> blk_clk[i])
            else $error("block clock missed its true global clock");

        chk_blk_inv_pick: assert property (@(posedge clk) disable iff (reset)
            run && src[i] && pol[i] && gclk[2 * (i / 2) + 1] |=> !blk_clk[i])
            else $error("block clock missed inverted odd global clock");
    end

    // Next state
    always_comb begin
        nx = st;
        nx.bclk = run ? want : '0;
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign blk_clk = st.bclk;

endmodule

// ===== lbc_alloc.sv
// Purpose: Product-term allocator, clusters, steering and output XOR
// Assumes: Five terms per cell, cluster steered to one of four cells
// Notes: No wrap at the ends of the block; purely combinational
`timescale 1ns/1ps
module lbc_alloc
    import lbc_pkg::*;
#(
    parameter int N_CELLS = 16
)(
    lbc_alloc_if.alloc ab
);

    logic [N_CELLS-1:0] basic;
    logic [N_CELLS-1:0] clus;

    // Route code test, used for every direction
    function automatic logic sent(input logic [1:0] route, input logic [1:0] code);
        sent = (route == code);
    endfunction

    // ----------------------------------------------------------------
    // Per-cluster sums and steering
    // ----------------------------------------------------------------
    for (genvar c = 0; c < N_CELLS; c++) begin : g_cl
        logic from_up;
        logic from_dn;
        logic from_dn2;
        logic own;

        // Size set by the owning cell's mode, wherever it goes
        assign basic[c] = (ab.mode[c] == MODE_ASYNC) ? |ab.pt[c*PTC +: ASYNC_BASIC] :
                          |ab.pt[c*PTC +: SYNC_BASIC];
        // Extra term joins the cluster when extended
        assign clus[c] = basic[c] | (ab.ext[c] & ab.pt[c*PTC + EXTRA_PT]);
        assign own = sent(ab.route[2*c +: 2], ROUTE_OWN);

        // Clusters arriving from neighbours, none past the ends
        if (c + 1 < N_CELLS) begin : g_up
            assign from_up = sent(ab.route[2*(c+1) +: 2], ROUTE_DOWN) & clus[c+1];
        end else begin : g_noup
            assign from_up = 1'b0;
        end
        if (c >= 1) begin : g_dn
            assign from_dn = sent(ab.route[2*(c-1) +: 2], ROUTE_UP) & clus[c-1];
        end else begin : g_nodn
            assign from_dn = 1'b0;
        end
        if (c >= 2) begin : g_dn2
            assign from_dn2 = sent(ab.route[2*(c-2) +: 2], ROUTE_UP2) & clus[c-2];
        end else begin : g_nodn2
            assign from_dn2 = 1'b0;
        end

        // Vacated cell sees 0 on the first XOR input
        assign ab.xor_a[c] = own ? (clus[c] | from_up | from_dn | from_dn2) : 1'b0;
        // Constant polarity when extended, else the extra term
        assign ab.xor_b[c] = ab.ext[c] ? ab.pol[c] : ab.pt[c*PTC + EXTRA_PT];
        assign ab.d[c] = ab.xor_a[c] ^ ab.xor_b[c];

        chk_vacated_zero: assert property (@(posedge ab.clk) disable iff (ab.reset)
            !own |-> !ab.xor_a[c] && (ab.d[c] == ab.xor_b[c]))
            else $error("vacated cell first xor input not zero");

        chk_polarity_const: assert property (@(posedge ab.clk) disable iff (ab.reset)
            ab.ext[c] |-> ab.d[c] == (ab.xor_a[c] ^ ab.pol[c]))
            else $error("extended cluster polarity not the constant");

        chk_sync_four: assert property (@(posedge ab.clk) disable iff (ab.reset)
            own && ab.mode[c] == MODE_SYNC && ab.pt[c*PTC + SYNC_BASIC - 1] |-> ab.xor_a[c])
            else $error("sync cluster lost its fourth term");

        chk_async_two: assert property (@(posedge ab.clk) disable iff (ab.reset)
            own && ab.mode[c] == MODE_ASYNC && ab.pt[c*PTC + ASYNC_BASIC - 1] |-> ab.xor_a[c])
            else $error("async cluster lost its second term");
    end

endmodule

// ===== lbc_block.sv
// Purpose: Logic block top: switch matrices, term array, allocator, block clocks
// Assumes: All inputs synchronous to clk; configuration loaded while run is low
// Notes: Macrocell storage lies outside; cell outputs feed it
`timescale 1ns/1ps
module lbc_block
    import lbc_pkg::*;
#(
    parameter int N_DED = DEF_N_DED,
    parameter int N_IN = DEF_N_IN,
    parameter int N_PINS = DEF_N_PINS,
    parameter int CELLS_PER_PIN = DEF_CELLS_PER_PIN
)(
    input logic clk,
    input logic reset,
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wr_data,
    input logic wr_en,
    input logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    input logic global_clock_0,
    input logic global_clock_1,
    input logic global_clock_2,
    input logic global_clock_3,
    input logic [N_DED-1:0] ded_in,
    input logic [N_PINS-1:0] pin_in,
    output logic blk_clock_0,
    output logic blk_clock_1,
    output logic blk_clock_2,
    output logic blk_clock_3,
    output logic [N_PINS*CELLS_PER_PIN-1:0] cell_d,
    output logic [N_PINS*CELLS_PER_PIN-1:0] cell_clock,
    output logic [N_PINS*CELLS_PER_PIN-1:0] cell_reset,
    output logic [N_PINS*CELLS_PER_PIN-1:0] cell_preset
);

    // ----------------------------------------------------------------
    // Derived sizes and configuration layout
    // ----------------------------------------------------------------
    localparam int N_CELLS = N_PINS * CELLS_PER_PIN;
    localparam int N_SRC = N_DED + N_GCLK + N_CELLS;
    localparam int SRC_W = $clog2(N_SRC);
    localparam int N_PT = PTC * N_CELLS + BLOCK_TERMS;
    localparam int LIT_W = 2 * N_IN;
    localparam int OFS_CLK = 0;
    localparam int OFS_CELL = OFS_CLK + CK_CFG_W;
    localparam int OFS_ISW = OFS_CELL + N_CELLS * CELL_CFG_W;
    localparam int OFS_CSM = OFS_ISW + N_CELLS * ISW_W;
    localparam int OFS_PT = OFS_CSM + N_IN * SRC_W;
    localparam int CFG_BITS = OFS_PT + N_PT * LIT_W;
    localparam int CFG_WORDS = (CFG_BITS + DATA_W - 1) / DATA_W;
    localparam logic [ADDR_W-1:0] CFG_LAST = ADDR_W'(int'(REG_CFG_BASE) + 4 * (CFG_WORDS - 1));
    localparam int AR_PT = PTC * N_CELLS;
    localparam int AP_PT = AR_PT + 1;

    typedef struct packed {
        logic run;
        logic [CFG_WORDS*DATA_W-1:0] cfg;
        logic [DATA_W-1:0] rd_data;
        logic [N_GCLK-1:0] gclk_q;
        logic [N_DED-1:0] ded_q;
        logic [N_PINS-1:0] pin_q;
        logic [N_PINS-1:0] pin_reg;
        logic [N_CELLS-1:0] cell_d;
        logic [N_CELLS-1:0] cell_clock;
        logic [N_CELLS-1:0] cell_reset;
        logic [N_CELLS-1:0] cell_preset;
    } lbc_state_type;

    lbc_state_type st;
    lbc_state_type nx;

    logic cfg_hit;
    logic [ADDR_W-1:0] cfg_idx;
    logic [DATA_W-1:0] cfg_word;
    logic [N_BCLK-1:0] bclk;
    logic [N_PINS-1:0] pin_src;
    logic [N_CELLS-1:0] isw_out;
    logic [N_SRC-1:0] src_vec;
    logic [N_IN-1:0] blk_in;
    logic [LIT_W-1:0] lit;
    logic [N_PT-1:0] pt;
    logic [N_CELLS-1:0] cmode;
    logic [N_CELLS-1:0] nxt_clock;
    logic [N_CELLS-1:0] nxt_reset;
    logic [N_CELLS-1:0] nxt_preset;

    lbc_alloc_if #(.N_CELLS(N_CELLS)) ab();

    // ----------------------------------------------------------------
    // Register port decode
    // ----------------------------------------------------------------
    assign cfg_hit = (addr >= REG_CFG_BASE) && (addr <= CFG_LAST) && (addr[1:0] == 2'h0);
    assign cfg_idx = (addr - REG_CFG_BASE) >> 2;
    assign cfg_word = st.cfg[cfg_idx*DATA_W +: DATA_W];

    // ----------------------------------------------------------------
    // Block clock generator
    // ----------------------------------------------------------------
    lbc_clkgen #(.NB(N_BCLK)) u_clkgen (
        .clk(clk),
        .reset(reset),
        .run(st.run),
        .gclk(st.gclk_q),
        .src(st.cfg[OFS_CLK + CK_SRC_LSB +: N_BCLK]),
        .pol(st.cfg[OFS_CLK + CK_POL_LSB +: N_BCLK]),
        .blk_clk(bclk)
    );

    // ----------------------------------------------------------------
    // Input switch matrix and pin input registers
    // ----------------------------------------------------------------
    // Second-stage input register only on the two-cells-per-pin family
    assign pin_src = (CELLS_PER_PIN == 2) ? st.pin_reg : st.pin_q;

    // Central matrix sources: switch outputs, global clocks, dedicated inputs
    assign src_vec = {isw_out, st.gclk_q, st.ded_q};

    // True and complement literals for the AND array
    assign lit = {~blk_in, blk_in};

    // ----------------------------------------------------------------
    // Per-cell settings, switch slots and controls
    // ----------------------------------------------------------------
    for (genvar c = 0; c < N_CELLS; c++) begin : g_cell
        localparam int P = c / CELLS_PER_PIN;
        localparam int PN = (P + 1) % N_PINS;
        localparam int CN = (c + 1) % N_CELLS;
        logic [CELL_CFG_W-1:0] f;
        logic [ISW_W-1:0] isel;

        assign f = st.cfg[OFS_CELL + c*CELL_CFG_W +: CELL_CFG_W];
        assign isel = st.cfg[OFS_ISW + c*ISW_W +: ISW_W];
        assign cmode[c] = f[CF_MODE];
        assign ab.mode[c] = f[CF_MODE];
        assign ab.route[2*c +: 2] = f[CF_ROUTE +: 2];
        assign ab.ext[c] = f[CF_EXT];
        assign ab.pol[c] = f[CF_POL];

        // Each feedback has two slots into the central matrix, each pin twice CELLS_PER_PIN slots
        assign isw_out[c] = (isel == ISW_PIN) ? pin_src[P] :
                            (isel == ISW_FB) ? st.cell_d[c] :
                            (isel == ISW_PIN_NEXT) ? pin_src[PN] : st.cell_d[CN];

        // Async cells take clock from a term of their own cluster
        assign nxt_clock[c] = (f[CF_MODE] == MODE_ASYNC) ?
                              (pt[c*PTC + ASYNC_CLK_PT] ^ f[CF_PTCLK_POL]) :
                              bclk[f[CF_CLK +: 2]];

        // Bank terms for sync cells, own init term for async cells
        assign nxt_reset[c] = (f[CF_MODE] == MODE_ASYNC) ?
                              (pt[c*PTC + ASYNC_INIT_PT] & ~f[CF_INIT_PRE]) :
                              pt[AR_PT];
        assign nxt_preset[c] = (f[CF_MODE] == MODE_ASYNC) ?
                               (pt[c*PTC + ASYNC_INIT_PT] & f[CF_INIT_PRE]) :
                               pt[AP_PT];

        chk_bank_reset: assert property (@(posedge clk) disable iff (reset)
            st.run && nx.run && cmode[c] == MODE_SYNC && pt[AR_PT] |=> cell_reset[c])
            else $error("sync cell missed bank reset");

        chk_async_ignore: assert property (@(posedge clk) disable iff (reset)
            st.run && nx.run && cmode[c] == MODE_ASYNC && pt[AR_PT] && pt[AP_PT]
            && !pt[c*PTC + ASYNC_INIT_PT] |=> !cell_reset[c] && !cell_preset[c])
            else $error("async cell followed bank init");

        chk_fb_route: assert property (@(posedge clk) disable iff (reset)
            st.run && nx.run && isel == ISW_FB && ab.d[c] |=> isw_out[c])
            else $error("feedback path did not return cell output");

        // Cell clock and initialization follow the cell's own mode
        chk_sync_clock: assert property (@(posedge clk) disable iff (reset)
            st.run && cmode[c] == MODE_SYNC && bclk[f[CF_CLK +: 2]] |=> cell_clock[c])
            else $error("sync cell missed its block clock");

        chk_term_clock_hi: assert property (@(posedge clk) disable iff (reset)
            st.run && cmode[c] == MODE_ASYNC
            && pt[c*PTC + ASYNC_CLK_PT] != f[CF_PTCLK_POL] |=> cell_clock[c])
            else $error("async cell missed its term clock high");

        chk_term_clock_lo: assert property (@(posedge clk) disable iff (reset)
            st.run && cmode[c] == MODE_ASYNC
            && pt[c*PTC + ASYNC_CLK_PT] == f[CF_PTCLK_POL] |=> !cell_clock[c])
            else $error("async cell missed its term clock low");

        chk_bank_preset: assert property (@(posedge clk) disable iff (reset)
            st.run && cmode[c] == MODE_SYNC && pt[AP_PT] |=> cell_preset[c])
            else $error("sync cell missed bank preset");

        chk_own_init: assert property (@(posedge clk) disable iff (reset)
            st.run && cmode[c] == MODE_ASYNC && pt[c*PTC + ASYNC_INIT_PT]
            |=> cell_reset[c] != cell_preset[c])
            else $error("async cell init term not applied once");
    end

    // ----------------------------------------------------------------
    // Central switch matrix
    // ----------------------------------------------------------------
    for (genvar i = 0; i < N_IN; i++) begin : g_csm
        logic [SRC_W-1:0] sel;

        assign sel = st.cfg[OFS_CSM + i*SRC_W +: SRC_W];
        // Out-of-range selections give a steady 0
        assign blk_in[i] = (int'(sel) < N_SRC) ? src_vec[sel] : 1'b0;
    end

    // Global clock 0 seen as plain logic through the matrix
    chk_gclk_input: assert property (@(posedge clk) disable iff (reset)
        st.run && nx.run && int'(g_csm[0].sel) == N_DED && global_clock_0 |=> blk_in[0])
        else $error("global clock not usable as logic input");

    // ----------------------------------------------------------------
    // Product-term AND array
    // ----------------------------------------------------------------
    for (genvar t = 0; t < N_PT; t++) begin : g_pt
        logic [LIT_W-1:0] mask;

        assign mask = st.cfg[OFS_PT + t*LIT_W +: LIT_W];
        // Unprogrammed term reads 0
        assign pt[t] = (|mask) & (&(~mask | lit));
    end

    // ----------------------------------------------------------------
    // Allocator hookup
    // ----------------------------------------------------------------
    assign ab.clk = clk;
    assign ab.reset = reset;
    assign ab.pt = pt[PTC*N_CELLS-1:0];

    lbc_alloc #(.N_CELLS(N_CELLS)) u_alloc (
        .ab(ab)
    );

    // ----------------------------------------------------------------
    // Next state: sampling, registers, cell outputs
    // ----------------------------------------------------------------
    always_comb begin
        nx = st;
        nx.gclk_q = {global_clock_3, global_clock_2, global_clock_1, global_clock_0};
        nx.ded_q = ded_in;
        nx.pin_q = pin_in;
        nx.pin_reg = st.pin_q;
        nx.rd_data = '0;
        // Writes; configuration locked while running
        if (wr_en) begin
            if (addr == REG_CTRL) begin
                nx.run = wr_data[CTRL_RUN_BIT];
            end else if (cfg_hit && !st.run) begin
                nx.cfg[cfg_idx*DATA_W +: DATA_W] = wr_data;
            end
        end
        // Reads answer in the next cycle
        if (rd_en) begin
            if (addr == REG_CTRL) begin
                nx.rd_data = DATA_W'(st.run);
            end else if (addr == REG_STATUS) begin
                nx.rd_data = DATA_W'({bclk, st.cell_d});
            end else if (cfg_hit) begin
                nx.rd_data = cfg_word;
            end else begin
                nx.rd_data = '0;
            end
        end
        // Cell outputs held low until the block runs
        nx.cell_d = st.run ? ab.d : '0;
        nx.cell_clock = st.run ? nxt_clock : '0;
        nx.cell_reset = st.run ? nxt_reset : '0;
        nx.cell_preset = st.run ? nxt_preset : '0;
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
            st.run <= CTRL_RUN_RESET;
        end else begin
            st <= nx;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_data = st.rd_data;
    assign blk_clock_0 = bclk[0];
    assign blk_clock_1 = bclk[1];
    assign blk_clock_2 = bclk[2];
    assign blk_clock_3 = bclk[3];
    assign cell_d = st.cell_d;
    assign cell_clock = st.cell_clock;
    assign cell_reset = st.cell_reset;
    assign cell_preset = st.cell_preset;

    // ----------------------------------------------------------------
    // Register port checks
    // ----------------------------------------------------------------
    sequence s_cfg_read;
        rd_en && cfg_hit;
    endsequence

    sequence s_cfg_write_running;
        wr_en && cfg_hit && st.run;
    endsequence

    chk_cfg_frozen: assert property (@(posedge clk) disable iff (reset)
        st.run |=> $stable(st.cfg))
        else $error("configuration changed while running");

    chk_cfg_write_drop: assert property (@(posedge clk) disable iff (reset)
        s_cfg_write_running |=> st.cfg == $past(st.cfg))
        else $error("write while running reached configuration");

    chk_cfg_readback: assert property (@(posedge clk) disable iff (reset)
        s_cfg_read |=> rd_data == $past(cfg_word) ##1 (rd_data == '0 || $past(rd_en)))
        else $error("configuration read back wrong or held too long");

    // Idle block keeps block clocks, cell outputs and read data low
    sequence s_idle;
        !st.run && !rd_en;
    endsequence

    chk_idle_quiet: assert property (@(posedge clk) disable iff (reset)
        s_idle |=> rd_data == '0 && bclk == '0 && cell_d == '0 && cell_reset == '0)
        else $error("idle block drove an output");

    chk_status_upper: assert property (@(posedge clk) disable iff (reset)
        rd_en && addr == REG_STATUS |=> rd_data[DATA_W-1:N_BCLK+N_CELLS] == '0)
        else $error("status word upper bits not zero");

    chk_rd_idle: assert property (@(posedge clk) disable iff (reset)
        !rd_en |=> rd_data == '0)
        else $error("read data stood without a read");

endmodule

// ===== lbc_testbench.sv
// Purpose: Self-checking bench for the logic block top
// Assumes: Configuration written while run is low, save one write that checks the lock
// Notes: Block clocks and cell data observed through the status word
`timescale 1ns/1ps
module testbench;
    import lbc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic [3:0] g = 4'h0;
    logic [7:0] ded = 8'h00;
    logic [7:0] pin = 8'h00;
    logic rd_q = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] val;
    logic [11:0] wa;
    logic [3:0] blk;
    logic [3:0] bo;
    logic [15:0] cd, cc, cr, cp;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 32'hd1fadb00;

    lbc_block dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .global_clock_0(g[0]), .global_clock_1(g[1]),
        .global_clock_2(g[2]), .global_clock_3(g[3]), .ded_in(ded), .pin_in(pin),
        .blk_clock_0(bo[0]), .blk_clock_1(bo[1]), .blk_clock_2(bo[2]), .blk_clock_3(bo[3]),
        .cell_d(cd), .cell_clock(cc), .cell_reset(cr), .cell_preset(cp));

    // ----------------------------------------------------------------
    // Clock, compare and verdict
    // ----------------------------------------------------------------
    initial forever #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string name);
        checks_done++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
            end else begin
                check(rd_data, exp_q.pop_front(), "rd_data");
            end
        end
        rd_q <= rd_en;
    end

    // ----------------------------------------------------------------
    // Register bus master
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        ded <= 8'($random(seed));
        pin <= 8'($random(seed));
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(REG_CTRL, 32'h0);
        rd(REG_STATUS, 32'h0);
        rd(REG_CFG_BASE, 32'h0);
        wr(12'h008, 32'hA5A5A5A5);
        rd(12'h008, 32'h0);
        rd(12'h101, 32'h0);
        rd(12'h3D4, 32'h0);
        // Random configuration words read back, then cleared
        repeat (8) begin
            wa = REG_CFG_BASE + 12'(4 * (1 + $unsigned($random(seed)) % 179));
            val = $random(seed);
            wr(wa, val);
            rd(wa, val);
            wr(wa, 32'h0);
        end
        // Every source pairing with random polarity and cell 0 constant
        for (int s = 0; s < 16; s++) begin
            val = $random(seed);
            val = {19'h0, val[12:11], 3'h0, val[7:4], 4'(s)};
            wr(REG_CTRL, 32'h0);
            wr(REG_CFG_BASE, val);
            wr(REG_CTRL, 32'h1);
            g <= 4'($random(seed));
            repeat (6) @(posedge clk);
            for (int i = 0; i < 4; i++) begin
                blk[i] = g[2 * (i / 2) + int'(val[i])] ^ val[4 + i];
            end
            check(bo, blk, "blk_clock");
            rd(REG_STATUS, {12'h0, blk, 15'h0, val[11] & val[12]});
        end
        // Configuration locked while running
        wr(REG_CFG_BASE, ~val);
        rd(REG_CFG_BASE, val);
        rd(REG_CTRL, 32'h1);
        // Bank init, one async cell, input 0 fed by global clock 0
        wr(REG_CTRL, 32'h0);
        wr(12'h110, 32'h01000000);
        wr(12'h114, 32'h08000000);
        wr(12'h3C0, 32'h40000000);
        wr(12'h3CC, 32'h00000001);
        wr(REG_CFG_BASE, 32'h010218E0);
        wr(REG_CTRL, 32'h1);
        for (int k = 0; k < 2; k++) begin
            g <= 4'(k);
            repeat (6) @(posedge clk);
            check(bo, k ? 32'hD : 32'hE, "blk_clock");
            check(cd, 32'h1, "cell_d");
            check(cc, k ? 32'hFFFF : 32'h2, "cell_clock");
            check(cr, k ? 32'h0 : 32'hFFFD, "cell_reset");
            check(cp, k ? 32'h0 : 32'hFFFD, "cell_preset");
            rd(REG_STATUS, k ? 32'h000D0001 : 32'h000E0001);
        end
        repeat (3) @(posedge clk);
        summarize();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule
